//--- bench/bpp_pins.sv
`timescale 1ns/10ps
module bpp_pins #(parameter int W = 8) (
    // Pad side of one port
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] oe_n,
    input  wire logic [W-1:0] pu,
    input  wire logic [W-1:0] ext,
    input  wire logic [W-1:0] ext_en,
    output logic      [W-1:0] pad
);
    // A pad nobody drives or pulls floats; toggling keeps it from looking settled
    logic flt = 1'b0;
    always #7 flt = ~flt;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pad[i] = !oe_n[i] ? out[i] : ext_en[i] ? ext[i] : pu[i] ? 1'b1 : flt;
        end
    end
endmodule // bpp_pins

//--- bench/bpp_port_assertions.sv
`timescale 1ns/10ps
module bpp_port_assertions (
    // Clock, reset and core access
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       wdt_in_low_power,
    input wire logic [2:0] addr,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    // Mode and pins
    input wire logic       low_power,
    input wire logic [7:0] pa_gpio_sel,
    input wire logic [7:0] pa_nmos_sel,
    input wire logic [7:0] pa_out,
    input wire logic [7:0] pa_oe_n,
    input wire logic [7:0] pa_pullhigh,
    input wire logic [4:0] pb_out,
    input wire logic       wakeup
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    a_por_dir: assert property (disable iff (1'b0) rst && !wdt_in_low_power
        |=> pa_oe_n == 8'hff && pa_pullhigh == 8'h00) else $error("reset defaults wrong");
    a_wdt_keep: assert property (disable iff (1'b0) rst && wdt_in_low_power
        |=> $stable(pa_out) && $stable(pa_oe_n)) else $error("low power reset changed port");
    a_latch_hold: assert property (!wr_en |=> $stable(pa_out) && $stable(pb_out))
        else $error("output latch moved");
    a_data_write: assert property (wr_en && addr == 3'h0 |=> pa_out == $past(wr_data))
        else $error("port a latch write wrong");
    a_dir_write: assert property (wr_en && addr == 3'h1 |=> ##1 pa_oe_n == $past(wr_data, 2))
        else $error("direction not on enables");
    a_pb_write: assert property (wr_en && addr == 3'h4 |=> pb_out == $past(wr_data[4:0]))
        else $error("port b latch write wrong");
    a_pb_upper: assert property (rd_en && addr inside {3'h4, 3'h5, 3'h6}
        |=> rd_data[7:5] == 3'h0) else $error("port b upper bits set");
    a_unmapped_read: assert property (rd_en && addr == 3'h7 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_pu_gate: assert property ((pa_pullhigh & ~$past(pa_gpio_sel | pa_nmos_sel)) == 8'h00)
        else $error("pull-high on wrong function");
    a_wake_mode: assert property (wakeup |-> $past(low_power))
        else $error("wake outside low power");
    a_wake_pulse: assert property (wakeup |=> !wakeup) else $error("wake not a pulse");
    c_wake: cover property (wakeup);
    c_wdt: cover property (disable iff (1'b0) rst && wdt_in_low_power);
    c_unmapped: cover property (rd_en && addr == 3'h7);
endmodule // bpp_port_assertions

//--- bench/bpp_port_bench.sv
`timescale 1ns/10ps
module bpp_port_bench;
    import bpp_pkg::*;
    typedef struct packed {logic w; logic [2:0] a; logic [7:0] d; logic [7:0] e;} bpp_row_t;
    logic       clk = 1'h0, rst = 1'h1, wdt_in_low_power = 1'h0, wr_en = 1'h0, rd_en = 1'h0;
    logic       low_power = 1'h0, input_read_control = 1'h0, wakeup;
    logic [2:0] addr = 3'h0;
    logic [7:0] wr_data = 8'h00, rd_data, pa_in, pa_out, pa_oe_n, pa_pullhigh, a_ext = 8'hff;
    logic [7:0] pa_gpio_sel = 8'h00, pa_nmos_sel = 8'h00;
    logic [4:0] pb_gpio_sel = 5'h00, pb_nmos_sel = 5'h00, pb_in, pb_out, pb_oe_n, pb_pullhigh;
    int         n_fail = 0, n_tests = 0, n_wake = 0;
    bpp_row_t   rows [11] = '{{1'h0, 3'h1, 8'h00, 8'hff}, {1'h0, 3'h2, 8'h00, 8'h00},
        {1'h0, 3'h3, 8'h00, 8'h00}, {1'h0, 3'h5, 8'h00, 8'h1f}, {1'h0, 3'h6, 8'h00, 8'h00},
        {1'h1, 3'h1, 8'h0f, 8'h0f}, {1'h1, 3'h2, 8'ha5, 8'ha5}, {1'h1, 3'h3, 8'h3c, 8'h3c},
        {1'h1, 3'h5, 8'hff, 8'h1f}, {1'h1, 3'h6, 8'hff, 8'h1f}, {1'h1, 3'h7, 8'hff, 8'h00}};
    bpp_port DUT (.*);
    bpp_pins #(.W(8)) PA (.out(pa_out), .oe_n(pa_oe_n), .pu(pa_pullhigh), .ext(a_ext),
        .ext_en(8'hff), .pad(pa_in));
    bpp_pins #(.W(5)) PB (.out(pb_out), .oe_n(pb_oe_n), .pu(pb_pullhigh), .ext(5'h15),
        .ext_en(5'h1f), .pad(pb_in));
    initial forever #10 clk = ~clk;
    always @(posedge clk) if (wakeup === 1'b1) n_wake++;
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One register access; a read's data is settled when this returns
    task automatic acc(logic w, logic [2:0] a, logic [7:0] d);
        @(negedge clk);
        {wr_en, rd_en, addr, wr_data} = {w, !w, a, d};
        @(negedge clk);
        {wr_en, rd_en} = 2'b00;
    endtask
    task automatic results;
        if (n_fail == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'h0;
        foreach (rows[i]) begin
            if (rows[i].w) acc(1'h1, rows[i].a, rows[i].d);
            acc(1'h0, rows[i].a, 8'h00);
            chk("reg", rows[i].e, rd_data);
        end
        acc(1'h1, ADDR_PA_DATA, 8'h5a);
        chk("pa_out", 8'h5a, pa_out);
        chk("pa_oe_n", 8'h0f, pa_oe_n);
        a_ext = 8'hf6;
        repeat (6) @(negedge clk);
        acc(1'h0, ADDR_PA_DATA, 8'h00);
        chk("pa_rd", 8'h56, rd_data);
        acc(1'h0, ADDR_PB_DATA, 8'h00);
        chk("pb_rd", 8'h15, rd_data);
        acc(1'h1, ADDR_PB_DATA, 8'hea);
        acc(1'h1, ADDR_PB_DIR, 8'h00);
        acc(1'h0, ADDR_PB_DATA, 8'h00);
        chk("pb_latch", 8'h0a, rd_data);
        chk("pb_oe_n", 8'h00, {3'h0, pb_oe_n});
        input_read_control = 1'h1;
        acc(1'h0, ADDR_PA_DATA, 8'h00);
        chk("pa_irc", 8'h56, rd_data);
        input_read_control = 1'h0;
        pa_gpio_sel = 8'hff;
        @(negedge clk);
        chk("pa_pu", 8'h05, pa_pullhigh);
        {pa_gpio_sel, pa_nmos_sel} = 16'h00ff;
        @(negedge clk);
        chk("pa_pu_nmos", 8'ha5, pa_pullhigh);
        {pa_nmos_sel, pb_gpio_sel} = {8'h00, 5'h1f};
        @(negedge clk);
        chk("pa_pu_off", 8'h00, pa_pullhigh);
        chk("pb_pu_out", 8'h00, pb_pullhigh);
        {pa_gpio_sel, low_power} = 9'h1ff;
        repeat (2) @(negedge clk);
        a_ext = 8'hf2;
        repeat (10) @(negedge clk);
        chk("wake", 8'h01, n_wake[7:0]);
        a_ext = 8'hf0;
        repeat (10) @(negedge clk);
        chk("wake_off", 8'h01, n_wake[7:0]);
        low_power = 1'h0;
        a_ext = 8'hf8;
        repeat (10) @(negedge clk);
        a_ext = 8'hf0;
        repeat (10) @(negedge clk);
        chk("wake_run", 8'h01, n_wake[7:0]);
        {wdt_in_low_power, rst} = 2'b11;
        repeat (2) @(negedge clk);
        {wdt_in_low_power, rst} = 2'b00;
        chk("wdt_keep", 8'h5a, pa_out);
        rst = 1'h1;
        repeat (2) @(negedge clk);
        rst = 1'h0;
        chk("por_out", RST_PA_DATA, pa_out);
        chk("por_dir", RST_PA_DIR, pa_oe_n);
        results();
    end
endmodule // bpp_port_bench
bind bpp_port bpp_port_assertions u_chk (.*);

//--- rtl/bpp_pkg.sv
package bpp_pkg;
    // ****************************************
    // Register addresses within the port window
    // ****************************************
    localparam logic [2:0] ADDR_PA_DATA = 3'h0;
    localparam logic [2:0] ADDR_PA_DIR  = 3'h1;
    localparam logic [2:0] ADDR_PA_PU   = 3'h2;
    localparam logic [2:0] ADDR_PA_WU   = 3'h3;
    localparam logic [2:0] ADDR_PB_DATA = 3'h4;
    localparam logic [2:0] ADDR_PB_DIR  = 3'h5;
    localparam logic [2:0] ADDR_PB_PU   = 3'h6;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_PA_DATA = 8'hff;
    localparam logic [7:0] RST_PA_DIR  = 8'hff;
    localparam logic [7:0] RST_PA_PU   = 8'h00;
    localparam logic [7:0] RST_PA_WU   = 8'h00;
    localparam logic [4:0] RST_PB_DATA = 5'h1f;
    localparam logic [4:0] RST_PB_DIR  = 5'h1f;
    localparam logic [4:0] RST_PB_PU   = 5'h00;
    localparam int         PA_W        = 8;
    localparam int         PB_W        = 5;
endpackage

//--- rtl/bpp_port.sv
`timescale 1ns/10ps
module bpp_port (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    wdt_in_low_power,
    // Core data memory access
    input  wire logic [2:0]              addr,
    input  wire logic                    wr_en,
    input  wire logic                    rd_en,
    input  wire logic [7:0]              wr_data,
    output logic      [7:0]              rd_data,
    // Mode and pin function
    input  wire logic                    low_power,
    input  wire logic                    input_read_control,
    input  wire logic [bpp_pkg::PA_W-1:0] pa_gpio_sel,
    input  wire logic [bpp_pkg::PA_W-1:0] pa_nmos_sel,
    input  wire logic [bpp_pkg::PB_W-1:0] pb_gpio_sel,
    input  wire logic [bpp_pkg::PB_W-1:0] pb_nmos_sel,
    // Pins
    input  wire logic [bpp_pkg::PA_W-1:0] pa_in,
    output logic      [bpp_pkg::PA_W-1:0] pa_out,
    output logic      [bpp_pkg::PA_W-1:0] pa_oe_n,
    output logic      [bpp_pkg::PA_W-1:0] pa_pullhigh,
    input  wire logic [bpp_pkg::PB_W-1:0] pb_in,
    output logic      [bpp_pkg::PB_W-1:0] pb_out,
    output logic      [bpp_pkg::PB_W-1:0] pb_oe_n,
    output logic      [bpp_pkg::PB_W-1:0] pb_pullhigh,
    // Wake-up request
    output logic                          wakeup
);
    import bpp_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [PA_W-1:0] port_a_data_r, port_a_data_nxt;
    logic [PA_W-1:0] port_a_direction_r, port_a_direction_nxt;
    logic [PA_W-1:0] port_a_pullhigh_enable_r, port_a_pullhigh_enable_nxt;
    logic [PA_W-1:0] port_a_wakeup_enable_r, port_a_wakeup_enable_nxt;
    logic [PB_W-1:0] port_b_data_r, port_b_data_nxt;
    logic [PB_W-1:0] port_b_direction_r, port_b_direction_nxt;
    logic [PB_W-1:0] port_b_pullhigh_enable_r, port_b_pullhigh_enable_nxt;
    logic [7:0]      rd_data_r, rd_data_nxt;

    // Three-stage sync; a level counts once stages two and three agree
    logic [PA_W-1:0] pa_s1_r, pa_s2_r, pa_s3_r, pa_q_r, pa_q_nxt;
    logic [PB_W-1:0] pb_s1_r, pb_s2_r, pb_s3_r, pb_q_r, pb_q_nxt;
    logic [PA_W-1:0] pa_ph_nxt, pa_oe_nxt;
    logic [PB_W-1:0] pb_ph_nxt, pb_oe_nxt;
    logic            wakeup_r, wakeup_nxt;

    // Output pins read latch unless input-read control asks for the pad
    function automatic logic [7:0] port_view(input logic [7:0] pin, input logic [7:0] lat,
                                             input logic [7:0] dir, input logic irc);
        port_view = irc ? pin : ((pin & dir) | (lat & ~dir));
    endfunction

    // Port B bits above the implemented pins always read as zero
    function automatic logic [7:0] pb_wide(input logic [PB_W-1:0] v);
        pb_wide = {{(8-PB_W){1'b0}}, v};
    endfunction

    // ****************************************
    // Elaboration checks
    // ****************************************
    // The read mux places port A straight on the data bus
    if (PA_W != 8) begin : g_pa_width_bad
        $error("port a width must equal the data bus width");
    end
    // Port B needs at least one zero-filled bit above its pins
    if (PB_W < 1 || PB_W > 7) begin : g_pb_width_bad
        $error("port b width must be from 1 to 7");
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        port_a_data_nxt            = port_a_data_r;
        port_a_direction_nxt       = port_a_direction_r;
        port_a_pullhigh_enable_nxt = port_a_pullhigh_enable_r;
        port_a_wakeup_enable_nxt   = port_a_wakeup_enable_r;
        port_b_data_nxt            = port_b_data_r;
        port_b_direction_nxt       = port_b_direction_r;
        port_b_pullhigh_enable_nxt = port_b_pullhigh_enable_r;
        if (wr_en) begin
            unique case (addr)
                ADDR_PA_DATA: port_a_data_nxt            = wr_data;
                ADDR_PA_DIR:  port_a_direction_nxt       = wr_data;
                ADDR_PA_PU:   port_a_pullhigh_enable_nxt = wr_data;
                ADDR_PA_WU:   port_a_wakeup_enable_nxt   = wr_data;
                ADDR_PB_DATA: port_b_data_nxt            = wr_data[PB_W-1:0];
                ADDR_PB_DIR:  port_b_direction_nxt       = wr_data[PB_W-1:0];
                ADDR_PB_PU:   port_b_pullhigh_enable_nxt = wr_data[PB_W-1:0];
                default: ;
            endcase
        end

        pa_q_nxt = (pa_s2_r == pa_s3_r) ? pa_s3_r : pa_q_r;
        pb_q_nxt = (pb_s2_r == pb_s3_r) ? pb_s3_r : pb_q_r;

        rd_data_nxt = rd_data_r;
        if (rd_en) begin
            unique case (addr)
                ADDR_PA_DATA: rd_data_nxt = port_view(pa_q_r, port_a_data_r,
                                                      port_a_direction_r, input_read_control);
                ADDR_PA_DIR:  rd_data_nxt = port_a_direction_r;
                ADDR_PA_PU:   rd_data_nxt = port_a_pullhigh_enable_r;
                ADDR_PA_WU:   rd_data_nxt = port_a_wakeup_enable_r;
                ADDR_PB_DATA: rd_data_nxt = port_view(pb_wide(pb_q_r), pb_wide(port_b_data_r),
                                                      pb_wide(port_b_direction_r),
                                                      input_read_control);
                ADDR_PB_DIR:  rd_data_nxt = pb_wide(port_b_direction_r);
                ADDR_PB_PU:   rd_data_nxt = pb_wide(port_b_pullhigh_enable_r);
                default:      rd_data_nxt = 8'h00;
            endcase
        end

        // Direction 0 drives CMOS output; active-low enable
        pa_oe_nxt = port_a_direction_r;
        pb_oe_nxt = port_b_direction_r;
        // Pull-high only for digital input or NMOS output function
        pa_ph_nxt = port_a_pullhigh_enable_r
                  & ((pa_gpio_sel & port_a_direction_r) | pa_nmos_sel);
        pb_ph_nxt = port_b_pullhigh_enable_r
                  & ((pb_gpio_sel & port_b_direction_r) | pb_nmos_sel);

        // Falling edge of debounced level on enabled general inputs
        wakeup_nxt = low_power
                   & |(pa_q_r & ~pa_q_nxt & port_a_wakeup_enable_r
                       & port_a_direction_r & pa_gpio_sel);
    end

    // ****************************************
    // Registers
    // ****************************************
    // Watchdog time-out in low power keeps all contents
    always_ff @(posedge clk) begin
        if (rst && !wdt_in_low_power) begin
            port_a_data_r            <= RST_PA_DATA;
            port_a_direction_r       <= RST_PA_DIR;
            port_a_pullhigh_enable_r <= RST_PA_PU;
            port_a_wakeup_enable_r   <= RST_PA_WU;
            port_b_data_r            <= RST_PB_DATA;
            port_b_direction_r       <= RST_PB_DIR;
            port_b_pullhigh_enable_r <= RST_PB_PU;
        end else if (!rst) begin
            port_a_data_r            <= port_a_data_nxt;
            port_a_direction_r       <= port_a_direction_nxt;
            port_a_pullhigh_enable_r <= port_a_pullhigh_enable_nxt;
            port_a_wakeup_enable_r   <= port_a_wakeup_enable_nxt;
            port_b_data_r            <= port_b_data_nxt;
            port_b_direction_r       <= port_b_direction_nxt;
            port_b_pullhigh_enable_r <= port_b_pullhigh_enable_nxt;
        end
    end

    // ****************************************
    // Pad synchronisers
    // ****************************************
    // Stages run through every reset so the pad view is fresh when code resumes
    always_ff @(posedge clk) begin
        pa_s1_r <= pa_in;
        pa_s2_r <= pa_s1_r;
        pa_s3_r <= pa_s2_r;
        pb_s1_r <= pb_in;
        pb_s2_r <= pb_s1_r;
        pb_s3_r <= pb_s2_r;
    end

    // ****************************************
    // Settled pad level
    // ****************************************
    // Idle-high reset level keeps the wake detector from seeing a false edge
    always_ff @(posedge clk) begin
        if (rst && !wdt_in_low_power) begin
            pa_q_r <= RST_PA_DATA;
            pb_q_r <= RST_PB_DATA;
        end else if (!rst) begin
            pa_q_r <= pa_q_nxt;
            pb_q_r <= pb_q_nxt;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Held between reads so the core may take it late
    always_ff @(posedge clk) begin
        if (rst && !wdt_in_low_power) begin
            rd_data_r <= 8'h00;
        end else if (!rst) begin
            rd_data_r <= rd_data_nxt;
        end
    end

    // ****************************************
    // Pad controls
    // ****************************************
    // Registered so pads never see a glitch from the function selects
    always_ff @(posedge clk) begin
        if (rst && !wdt_in_low_power) begin
            pa_oe_n     <= RST_PA_DIR;
            pb_oe_n     <= RST_PB_DIR;
            pa_pullhigh <= RST_PA_PU;
            pb_pullhigh <= RST_PB_PU;
        end else if (!rst) begin
            pa_oe_n     <= pa_oe_nxt;
            pb_oe_n     <= pb_oe_nxt;
            pa_pullhigh <= pa_ph_nxt;
            pb_pullhigh <= pb_ph_nxt;
        end
    end

    // ****************************************
    // Wake-up pulse
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst && !wdt_in_low_power) begin
            wakeup_r <= 1'b0;
        end else if (!rst) begin
            wakeup_r <= wakeup_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign pa_out  = port_a_data_r;
    assign pb_out  = port_b_data_r;
    assign rd_data = rd_data_r;
    assign wakeup  = wakeup_r;
endmodule // bpp_port
